/* rtl/otf_pkg.sv */
// Package with register map, field layout and types of the over-temperature fault response block
package otf_pkg;
   // Command codes of the registers
   localparam logic [7:0] OTF_CMD_OC_WARN = 8'h4a;
   localparam logic [7:0] OTF_CMD_OT_LIMIT = 8'h4f;
   localparam logic [7:0] OTF_CMD_OT_ACTION = 8'h50;
   // Own command codes for clearing and status
   localparam logic [7:0] OTF_CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] OTF_CMD_STATUS = 8'h7d;
   // Reset values
   localparam logic [15:0] OTF_RST_OC_WARN = 16'h0000;
   localparam logic [15:0] OTF_RST_OT_LIMIT = 16'h7fff;
   localparam logic [7:0] OTF_RST_OT_ACTION = 8'hc0;
   // Action field positions
   localparam int OTF_RESP_HI = 7;
   localparam int OTF_RESP_LO = 6;
   localparam int OTF_RETRY_HI = 5;
   localparam int OTF_RETRY_LO = 3;
   localparam int OTF_DLY_HI = 2;
   localparam int OTF_DLY_LO = 0;
   // Response codes
   localparam logic [1:0] OTF_RESP_IGNORE = 2'h0;
   localparam logic [1:0] OTF_RESP_DELAYED = 2'h1;
   localparam logic [1:0] OTF_RESP_SHUTDOWN = 2'h2;
   localparam logic [1:0] OTF_RESP_LATCH = 2'h3;
   // Retry codes
   localparam logic [2:0] OTF_RETRY_NONE = 3'h0;
   localparam logic [2:0] OTF_RETRY_FOREVER = 3'h7;
   // Status bit positions (own layout)
   localparam int OTF_ST_OT_FAULT = 0;
   localparam int OTF_ST_OC_WARN = 1;
   localparam int OTF_ST_OUT_OFF = 2;
   // Register read or write request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] cmd;
      logic [15:0] data;
   } otf_req_t;
   // Measurements
   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] iout;
   } otf_meas_t;
endpackage : otf_pkg

/* rtl/otf_delay_timer.sv */
// Delay timer: counts 2**code time units, each unit a number of clock cycles
`timescale 1ns/1ps
module otf_delay_timer
   import otf_pkg::*;
#(
   parameter int UNIT_W = 24
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [2:0] code_i,
   input wire logic [UNIT_W-1:0] unit_cycles_i,
   output logic done_o
);
   logic [UNIT_W-1:0] cyc_q;
   logic [7:0] units_q;
   logic run_q;
   logic [7:0] units_total;
   logic unit_end;

   // Unit count doubles per code, 128 at code 7
   assign units_total = 8'h01 << code_i; // [R13]
   assign unit_end = (cyc_q == unit_cycles_i) || (unit_cycles_i == '0);
   // Done on the edge that closes the last unit, so restart starts keep exact spacing
   assign done_o = run_q && unit_end && (units_q + 8'h01 == units_total); // [R10]

   always_ff @(posedge clk_i) begin
      if (rst_i || start_i) begin
         cyc_q <= '0;
         units_q <= 8'h00;
         run_q <= start_i;
      end else begin
         if (run_q) begin
            if (unit_end) begin
               cyc_q <= '0;
               if (units_q + 8'h01 == units_total) begin
                  run_q <= 1'b0;
               end
               units_q <= units_q + 8'h01;
            end else begin
               cyc_q <= cyc_q + 1'b1;
            end
         end
      end
   end
endmodule : otf_delay_timer

/* rtl/otf_fault_ctrl.sv */
// Over-temperature fault response controller with its threshold registers
// Overview of operation
// [R1] Holds a host-writable 16-bit over-temperature threshold in linear format, Celsius.
// [R2] Holds a 16-bit output over-current warning threshold in linear format, amperes.
// [R3] Response 00: fault is flagged but the output keeps running.
// [R4] Response 01: run for the delay; if fault persists, apply retry behaviour.
// [R5] Response 10: disable output at once, then follow the retry setting.
// [R6] Response 11: disable output and hold it off until the fault is cleared.
// [R7] Latched faults clear by bit clear, clear command, reset, off-on cycle or bias loss.
// [R8] Retry 000: no restart; output stays off until cleared.
// [R9] Retry 001 to 100: one to four restarts, then off until cleared.
// [R10] Restart spacing is delay count times the configured time unit.
// [R11] Every response code sets the fault status bit and may alert the host.
// [R12] Retry 101, 110 give five, six restarts; 111 retries until commanded off.
// [R13] Delay code maps to a unit count doubling per code, 128 at code 7.
// [R14] Fault when temperature reaches threshold; warning when current exceeds its threshold.
`timescale 1ns/1ps
module otf_fault_ctrl
   import otf_pkg::*;
#(
   parameter int UNIT_W = 24
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire otf_req_t REQ_I,
   input wire otf_meas_t MEAS_I,
   input wire logic ENABLE_I,
   input wire logic BIAS_OK_I,
   input wire logic [UNIT_W-1:0] UNIT_CYCLES_I,
   output logic [15:0] RD_DATA_O,
   output logic OUTPUT_EN_O,
   output logic OT_FAULT_O,
   output logic OC_WARN_O,
   output logic ALERT_O
);
   typedef enum logic [4:0] {
      ST_RUN = 5'b00001,
      ST_GRACE = 5'b00010,
      ST_WAIT = 5'b00100,
      ST_RETRY = 5'b01000,
      ST_LOCK = 5'b10000
   } otf_state_t;

   // Elaboration checks
   initial begin
      if (UNIT_W < 1 || UNIT_W > 32) begin
         $error("UNIT_W out of range");
      end
      if (OTF_RESP_HI - OTF_RESP_LO != 1) begin
         $error("Response field must be two bits");
      end
      if (OTF_RETRY_HI - OTF_RETRY_LO != 2 || OTF_DLY_HI - OTF_DLY_LO != 2) begin
         $error("Retry and delay fields must be three bits");
      end
      if (OTF_ST_OUT_OFF > 15) begin
         $error("Status bit outside the status word");
      end
   end

   // Response state
   otf_state_t state_q;
   otf_state_t state_d;
   logic [2:0] tries_q;
   logic [2:0] tries_d;
   // Registers seen by the host
   logic [15:0] oc_warn_q;
   logic [15:0] ot_limit_q;
   logic [7:0] action_q;
   logic [15:0] rd_q;
   // Synchronisers
   logic [2:0] en_sync_q;
   logic [2:0] bias_sync_q;
   // Flags and output
   logic ot_flag_q;
   logic oc_flag_q;
   logic off_q;
   logic alert_q;
   logic outen_q;
   // Timer handshake
   logic tmr_start;
   logic tmr_done;

   // Field and command decoding
   function automatic logic [1:0] resp_of(input logic [7:0] act);
      resp_of = act[OTF_RESP_HI:OTF_RESP_LO];
   endfunction : resp_of

   function automatic logic [2:0] retry_of(input logic [7:0] act);
      retry_of = act[OTF_RETRY_HI:OTF_RETRY_LO];
   endfunction : retry_of

   function automatic logic [2:0] dly_of(input logic [7:0] act);
      dly_of = act[OTF_DLY_HI:OTF_DLY_LO];
   endfunction : dly_of

   function automatic logic wr_hit(input otf_req_t req, input logic [7:0] code);
      wr_hit = req.wr && (req.cmd == code);
   endfunction : wr_hit

   // States in which the output is driven
   function automatic logic out_on(input otf_state_t st);
      out_on = (st == ST_GRACE) || (st == ST_RUN) || (st == ST_RETRY);
   endfunction : out_on

   // Register read map; unknown commands read zero
   function automatic logic [15:0] read_mux(input logic [7:0] cmd, input logic [15:0] oc, input logic [15:0] ot,
                                            input logic [7:0] act, input logic [15:0] status);
      case (cmd)
         OTF_CMD_OC_WARN: read_mux = oc;
         OTF_CMD_OT_LIMIT: read_mux = ot;
         OTF_CMD_OT_ACTION: read_mux = {8'h00, act};
         OTF_CMD_STATUS: read_mux = status;
         default: read_mux = 16'h0000;
      endcase
   endfunction : read_mux

   wire [1:0] resp = resp_of(action_q);
   wire [2:0] retry = retry_of(action_q);
   wire [2:0] dly = dly_of(action_q);
   // Sign-free linear comparison on raw code words
   wire ot_now = (MEAS_I.temp >= ot_limit_q); // [R14]
   wire oc_now = (MEAS_I.iout > oc_warn_q); // [R14]
   wire wr_oc = wr_hit(REQ_I, OTF_CMD_OC_WARN);
   wire wr_ot = wr_hit(REQ_I, OTF_CMD_OT_LIMIT);
   wire wr_act = wr_hit(REQ_I, OTF_CMD_OT_ACTION);
   wire clr_all = wr_hit(REQ_I, OTF_CMD_CLEAR_FAULTS);
   wire clr_bit = wr_hit(REQ_I, OTF_CMD_STATUS);
   wire en_s = en_sync_q[1];
   wire en_rise = en_sync_q[1] && !en_sync_q[2];
   wire bias_s = bias_sync_q[1];
   wire clr_ot = clr_all || (clr_bit && REQ_I.data[OTF_ST_OT_FAULT]);
   wire clr_oc = clr_all || (clr_bit && REQ_I.data[OTF_ST_OC_WARN]);
   // Any clearing event ends a latched fault
   wire unlatch = clr_ot || en_rise || !bias_s; // [R7]
   wire tries_left = (retry == OTF_RETRY_FOREVER) || (tries_q != 3'h0); // [R12]
   wire [15:0] status_w = {13'h0000, off_q, oc_flag_q, ot_flag_q};
   wire [15:0] rd_d = read_mux(REQ_I.cmd, oc_warn_q, ot_limit_q, action_q, status_w);

   // Timer runs the grace delay and the restart spacing
   otf_delay_timer #(.UNIT_W(UNIT_W)) u_timer (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .start_i(tmr_start),
      .code_i(dly),
      .unit_cycles_i(UNIT_CYCLES_I),
      .done_o(tmr_done)
   );

   always_comb begin
      state_d = state_q;
      tries_d = tries_q;
      tmr_start = 1'b0;
      case (state_q)
         // Output on, watching the temperature
         ST_RUN: begin
            if (ot_now && en_s) begin
               case (resp)
                  OTF_RESP_IGNORE: state_d = ST_RUN; // [R3]
                  OTF_RESP_DELAYED: begin
                     state_d = ST_GRACE; // [R4]
                     tmr_start = 1'b1;
                  end
                  OTF_RESP_SHUTDOWN: begin
                     tries_d = retry;
                     tmr_start = 1'b1;
                     state_d = (retry == OTF_RETRY_NONE) ? ST_LOCK : ST_WAIT; // [R5] [R8]
                  end
                  default: state_d = ST_LOCK; // [R6]
               endcase
            end
         end
         // Output on for the programmed delay
         ST_GRACE: begin
            if (!ot_now) begin
               state_d = ST_RUN;
            end else if (tmr_done) begin
               tries_d = retry;
               tmr_start = 1'b1;
               state_d = (retry == OTF_RETRY_NONE) ? ST_LOCK : ST_WAIT; // [R4] [R8]
            end
         end
         // Output off between restart attempts
         ST_WAIT: begin
            if (!en_s) begin
               state_d = ST_LOCK; // [R12]
            end else if (tmr_done) begin
               state_d = ST_RETRY; // [R10]
               tmr_start = 1'b1;
               if (retry != OTF_RETRY_FOREVER) begin
                  tries_d = tries_q - 3'h1;
               end
            end
         end
         ST_RETRY: begin
            // Output is on during the attempt; a fault still present fails it
            // Timer keeps running from the attempt start, so spacing is start to start
            if (ot_now) begin
               state_d = tries_left ? ST_WAIT : ST_LOCK; // [R9] [R12]
            end else begin
               state_d = ST_RUN;
            end
         end
         // Output off until a clearing event
         ST_LOCK: begin
            if (unlatch) begin
               state_d = ST_RUN; // [R7]
            end
         end
         default: state_d = ST_LOCK;
      endcase
      if (unlatch && state_q != ST_RUN) begin
         state_d = ST_RUN; // [R7]
      end
   end

   // Enable and bias synchronisers
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         en_sync_q <= 3'h0;
         bias_sync_q <= 3'h0;
      end else begin
         en_sync_q <= {en_sync_q[1:0], ENABLE_I};
         bias_sync_q <= {bias_sync_q[1:0], BIAS_OK_I};
      end
   end

   // Response state and retry budget
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         state_q <= ST_RUN; // [R7]
         tries_q <= 3'h0;
      end else begin
         state_q <= state_d;
         tries_q <= tries_d;
      end
   end

   // Host-writable thresholds
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         oc_warn_q <= OTF_RST_OC_WARN;
         ot_limit_q <= OTF_RST_OT_LIMIT;
      end else begin
         if (wr_oc) begin
            oc_warn_q <= REQ_I.data; // [R2]
         end
         if (wr_ot) begin
            ot_limit_q <= REQ_I.data; // [R1]
         end
      end
   end

   // Response setting
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         action_q <= OTF_RST_OT_ACTION;
      end else if (wr_act) begin
         action_q <= REQ_I.data[7:0];
      end
   end

   // Sticky flags; set wins over clear
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         ot_flag_q <= 1'b0;
         oc_flag_q <= 1'b0;
         alert_q <= 1'b0;
      end else begin
         ot_flag_q <= (ot_now && en_s) || (ot_flag_q && !clr_ot); // [R11]
         oc_flag_q <= oc_now || (oc_flag_q && !clr_oc); // [R14]
         alert_q <= (ot_now && en_s) || oc_now || (alert_q && !clr_all); // [R11]
      end
   end

   // Output enable and off status follow the next state
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         off_q <= 1'b0;
         outen_q <= 1'b0;
      end else begin
         off_q <= !out_on(state_d);
         outen_q <= en_sync_q[1] && out_on(state_d); // [R3] [R5] [R6]
      end
   end

   // Read data register
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         rd_q <= 16'h0000;
      end else if (REQ_I.rd) begin
         rd_q <= rd_d;
      end
   end

   assign RD_DATA_O = rd_q;
   assign OUTPUT_EN_O = outen_q;
   assign OT_FAULT_O = ot_flag_q;
   assign OC_WARN_O = oc_flag_q;
   assign ALERT_O = alert_q;
endmodule : otf_fault_ctrl

/* verification/otf_properties.sv */
// Checker of the fault response block ports
`timescale 1ns/1ps
module otf_properties
   import otf_pkg::*;
#(
   parameter int UNIT_W = 24
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire otf_req_t REQ_I,
   input wire otf_meas_t MEAS_I,
   input wire logic ENABLE_I,
   input wire logic BIAS_OK_I,
   input wire logic [UNIT_W-1:0] UNIT_CYCLES_I,
   input wire logic [15:0] RD_DATA_O,
   input wire logic OUTPUT_EN_O,
   input wire logic OT_FAULT_O,
   input wire logic OC_WARN_O,
   input wire logic ALERT_O
);
   logic [7:0] act_q;
   logic [15:0] ot_q, oc_q;
   logic [3:0] run_q;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   wire clr_w = REQ_I.wr && (REQ_I.cmd == OTF_CMD_CLEAR_FAULTS || REQ_I.cmd == OTF_CMD_STATUS);
   wire steady_w = run_q == 4'h8;
   wire ign_w = act_q[7:6] == OTF_RESP_IGNORE;
   wire lock_w = !ign_w && (act_q[7:6] == OTF_RESP_LATCH || act_q[5:3] == OTF_RETRY_NONE);
   wire [15:0] exp_w = REQ_I.cmd == OTF_CMD_OC_WARN ? oc_q : REQ_I.cmd == OTF_CMD_OT_LIMIT ? ot_q :
      REQ_I.cmd == OTF_CMD_OT_ACTION ? {8'h00, act_q} : 16'h0000;
   // Shadow of the registers and a count of steady enable and bias
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         act_q <= OTF_RST_OT_ACTION;
         ot_q <= OTF_RST_OT_LIMIT;
         oc_q <= OTF_RST_OC_WARN;
         run_q <= 4'h0;
      end else begin
         if (REQ_I.wr && REQ_I.cmd == OTF_CMD_OT_ACTION) act_q <= REQ_I.data[7:0];
         if (REQ_I.wr && REQ_I.cmd == OTF_CMD_OT_LIMIT) ot_q <= REQ_I.data;
         if (REQ_I.wr && REQ_I.cmd == OTF_CMD_OC_WARN) oc_q <= REQ_I.data;
         run_q <= !(ENABLE_I && BIAS_OK_I) ? 4'h0 : steady_w ? run_q : run_q + 4'h1;
      end
   end
   rd_map_a: assert property (REQ_I.rd && REQ_I.cmd != OTF_CMD_STATUS |=> RD_DATA_O == $past(exp_w))
      else $error("read data wrong");
   ot_set_a: assert property (OUTPUT_EN_O && MEAS_I.temp >= ot_q |=> OT_FAULT_O)
      else $error("fault flag missing");
   oc_set_a: assert property (MEAS_I.iout > oc_q |=> OC_WARN_O)
      else $error("warning flag missing");
   ignore_run_a: assert property (steady_w && ign_w && $past(ign_w) && $past(ign_w, 3) && OUTPUT_EN_O |=> OUTPUT_EN_O)
      else $error("output dropped while ignoring");
   trip_off_a: assert property (OUTPUT_EN_O && act_q[7] && MEAS_I.temp >= ot_q |-> ##2 !OUTPUT_EN_O)
      else $error("output not disabled");
   hold_off_a: assert property (steady_w && lock_w && $stable(act_q) && OT_FAULT_O && !OUTPUT_EN_O && !clr_w
      |=> !OUTPUT_EN_O)
      else $error("locked output restarted");
   ot_alert_a: assert property ($rose(OT_FAULT_O) |-> ##[0:1] ALERT_O)
      else $error("alert missing");
   en_off_a: assert property (!ENABLE_I [*3] |=> !OUTPUT_EN_O)
      else $error("output on while commanded off");
   cover property (OT_FAULT_O && !OUTPUT_EN_O);
   cover property ($rose(OUTPUT_EN_O) && OT_FAULT_O);
   cover property (OC_WARN_O && OUTPUT_EN_O);
endmodule : otf_properties
bind otf_fault_ctrl otf_properties #(.UNIT_W(UNIT_W)) chk_u (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .REQ_I(REQ_I),
   .MEAS_I(MEAS_I), .ENABLE_I(ENABLE_I), .BIAS_OK_I(BIAS_OK_I), .UNIT_CYCLES_I(UNIT_CYCLES_I), .RD_DATA_O(RD_DATA_O),
   .OUTPUT_EN_O(OUTPUT_EN_O), .OT_FAULT_O(OT_FAULT_O), .OC_WARN_O(OC_WARN_O), .ALERT_O(ALERT_O));

/* verification/otf_host_model.sv */
// Host model issuing register requests
`timescale 1ns/1ps
module otf_host_model
   import otf_pkg::*;
(
   input wire logic clk_i,
   input wire logic [15:0] rd_data_i,
   output otf_req_t req_o
);
   initial req_o = '0;
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
      @(negedge clk_i);
      req_o = '{wr: w, rd: !w, cmd: c, data: d};
      @(negedge clk_i);
      req_o = '{wr: 1'b0, rd: 1'b0, cmd: ~c, data: ~d}; // Released lines show the inverse
      q = rd_data_i;
   endtask : xfer
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      logic [15:0] q;
      xfer(1'b1, c, d, q);
   endtask : wr
endmodule : otf_host_model

/* verification/tb_otf_fault_ctrl.sv */
// Testbench of the fault response block
`timescale 1ns/1ps
module tb_otf_fault_ctrl;
   import otf_pkg::*;
   logic clk = 1'b0, rst = 1'b1, en = 1'b1, bias = 1'b1, outen, ot, oc, alert;
   otf_req_t req;
   otf_meas_t meas = '0;
   logic [15:0] rdat;
   logic [3:0] unit = 4'h1;
   int fails = 0, samples_checked = 0, cyc = 0;
   always #4 clk = ~clk;
   always @(posedge clk) if (++cyc > 5000) begin
      fails++;
      report_and_stop();
   end
   otf_host_model host_u (.clk_i(clk), .rd_data_i(rdat), .req_o(req));
   otf_fault_ctrl #(.UNIT_W(4)) dut_u (.CLK_SYS_I(clk), .RST_I(rst), .REQ_I(req), .MEAS_I(meas), .ENABLE_I(en),
      .BIAS_OK_I(bias), .UNIT_CYCLES_I(unit), .RD_DATA_O(rdat), .OUTPUT_EN_O(outen), .OT_FAULT_O(ot),
      .OC_WARN_O(oc), .ALERT_O(alert));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rchk(input string what, input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] q;
      host_u.xfer(1'b0, c, 16'h0000, q);
      chk(what, q, exp);
   endtask : rchk
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n
   task automatic restore;
      meas = '0;
      en = 1'b0;
      wait_n(5);
      en = 1'b1;
      wait_n(5);
      host_u.wr(OTF_CMD_CLEAR_FAULTS, 16'h0000);
   endtask : restore
   task automatic t_regs;
      rchk("oc rst", OTF_CMD_OC_WARN, OTF_RST_OC_WARN);
      rchk("ot rst", OTF_CMD_OT_LIMIT, OTF_RST_OT_LIMIT);
      rchk("act rst", OTF_CMD_OT_ACTION, {8'h00, OTF_RST_OT_ACTION});
      host_u.wr(OTF_CMD_OT_LIMIT, 16'h0100);
      host_u.wr(OTF_CMD_OC_WARN, 16'h0200);
      host_u.wr(8'h20, 16'h5a5a);
      rchk("ot", OTF_CMD_OT_LIMIT, 16'h0100);
      rchk("oc", OTF_CMD_OC_WARN, 16'h0200);
      rchk("gap", 8'h20, 16'h0000);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_ignore;
      host_u.wr(OTF_CMD_OT_ACTION, 16'h0000);
      meas = '{temp: 16'h0100, iout: 16'h0201};
      wait_n(6);
      chk("on", 16'(outen), 16'h1);
      chk("ot", 16'(ot), 16'h1);
      chk("oc", 16'(oc), 16'h1);
      chk("alert", 16'(alert), 16'h1);
      rchk("status", OTF_CMD_STATUS, 16'h0003);
      meas = '0;
      host_u.wr(OTF_CMD_CLEAR_FAULTS, 16'h0000);
      wait_n(2);
      chk("cleared", {13'h0000, ot, oc, alert}, 16'h0000);
      $display("t_ignore done");
   endtask : t_ignore
   task automatic t_latch;
      host_u.wr(OTF_CMD_OT_ACTION, 16'h00c0);
      meas.temp = 16'h0100;
      wait_n(4);
      chk("off", 16'(outen), 16'h0);
      meas.temp = 16'h0000;
      wait_n(40);
      chk("held", 16'(outen), 16'h0);
      host_u.wr(OTF_CMD_STATUS, 16'h0001);
      wait_n(6);
      chk("resumed", {14'h0000, outen, ot}, 16'h0002);
      $display("t_latch done");
   endtask : t_latch
   task automatic t_retry;
      int rises;
      int t0;
      logic prev;
      for (int rc = 0; rc < 8; rc++) begin
         host_u.wr(OTF_CMD_OT_ACTION, {8'h00, 2'b10, rc[2:0], 3'h1});
         meas.temp = 16'h0100;
         rises = 0;
         prev = 1'b1;
         repeat (62) begin
            @(negedge clk);
            if (outen && !prev) begin
               if (rises == 1) chk("spacing", 16'(cyc - t0), 16'h0004);
               t0 = cyc;
               rises++;
            end
            prev = outen;
         end
         if (rc < 7) chk("attempts", 16'(rises), 16'(rc));
         else chk("endless", 16'(rises >= 10), 16'h0001);
         if (rc < 7) chk("final off", 16'(outen), 16'h0);
         restore();
      end
      $display("t_retry done");
   endtask : t_retry
   task automatic t_delay;
      host_u.wr(OTF_CMD_OT_ACTION, 16'h0043);
      meas.temp = 16'h0100;
      wait_n(10);
      chk("still on", 16'(outen), 16'h1);
      wait_n(12);
      chk("off after delay", 16'(outen), 16'h0);
      restore();
      $display("t_delay done");
   endtask : t_delay
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   initial begin
      wait_n(8);
      rst = 1'b0;
      wait_n(4);
      t_regs();
      t_ignore();
      t_latch();
      t_retry();
      t_delay();
      report_and_stop();
   end
endmodule : tb_otf_fault_ctrl
